// ==== hdl/lrpf_map.vh ====
// Purpose: Constants for the link receive phase FIFO.
// Assumes: Included by the receive module by bare name; the FIFO module does not include it.
// Notes: Timing counts are in core clock cycles at 40 MHz.
`ifndef LRPF_MAP_VH
`define LRPF_MAP_VH
// ----------------------------------------
// Widths and depths
// ----------------------------------------
`define LRPF_LINK_W 8
`define LRPF_WORD_W 9
`define LRPF_LINE_BYTES 4
`define LRPF_LINE_W 32
`define LRPF_RING_DEPTH 16
`define LRPF_RING_AW 4
`define LRPF_OUT_DEPTH 8
`define LRPF_OUT_AW 3
// ----------------------------------------
// Pointer placement and clocking modes
// ----------------------------------------
`define LRPF_INIT_OFFSET 4'h8
`define LRPF_MIN_SEP 4'h5
`define LRPF_MAX_SEP 4'hB
`define LRPF_MODE_SYNC 1'b0
`define LRPF_MODE_PSEUDO 1'b1
`endif

// ==== hdl/lrpf_fifo.v ====
// Purpose: Small synchronous FIFO with valid and ready on both sides.
// Assumes: One clock, synchronous active-high reset.
// Notes: Depth must be a power of two matching the address width.
`timescale 1ns/10ps
`default_nettype none
module lrpf_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire sys_clk_i,
	input wire srst_i,
	input wire in_valid_i,
	output wire in_ready_o,
	input wire [WIDTH-1:0] in_data_i,
	output wire out_valid_o,
	input wire out_ready_i,
	output wire [WIDTH-1:0] out_data_o
);
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW:0] wr_q;
	reg [AW:0] rd_q;
	wire full;
	wire empty;

	// ----------------------------------------
	// Status
	// ----------------------------------------
	// An extra pointer bit tells full from empty honestly.
	assign empty = (wr_q == rd_q);
	assign full = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
	assign in_ready_o = ~full;
	assign out_valid_o = ~empty;
	assign out_data_o = mem_q[rd_q[AW-1:0]];

	// Pointer and storage update.
	always @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			wr_q <= {(AW+1){1'b0}};
			rd_q <= {(AW+1){1'b0}};
		end
		else
		begin
			if (in_valid_i && !full)
			begin
				mem_q[wr_q[AW-1:0]] <= in_data_i;
				wr_q <= wr_q + 1'b1;
			end
			if (out_ready_i && !empty)
				rd_q <= rd_q + 1'b1;
		end
	end
endmodule
`default_nettype wire

// ==== hdl/lrpf_rx.v ====
// Purpose: Receive phase FIFO moving link words from the forwarded clock into the core clock.
// Assumes: Forwarded clock is far slower than the core clock; it is sampled, not used as a clock.
// Notes: Ring is written on forwarded clock edges, read by core logic at a set pointer distance.
`timescale 1ns/10ps
`default_nettype none
`include "lrpf_map.vh"
module lrpf_rx #(
	parameter RING_DEPTH = `LRPF_RING_DEPTH,
	parameter [`LRPF_RING_AW-1:0] INIT_OFFSET = `LRPF_INIT_OFFSET
) (
	input wire sys_clk_i,
	input wire srst_i,
	input wire link_init_i,
	input wire clk_mode_i,
	input wire forwarded_clock_input_i,
	input wire [`LRPF_LINK_W-1:0] link_data_input_i,
	input wire link_control_input_i,
	output wire line_valid_o,
	input wire line_ready_i,
	output wire [`LRPF_LINE_W-1:0] line_data_o,
	output wire [`LRPF_LINE_BYTES-1:0] line_ctl_o,
	output wire running_o,
	output reg overrun_o
);
	localparam AW = `LRPF_RING_AW;
	localparam ST_IDLE = 2'b00;
	localparam ST_WAIT_LOW = 2'b01;
	localparam ST_RUN = 2'b10;

	reg clk_s1_q;
	reg [`LRPF_WORD_W-1:0] word_s1_q;
	reg [`LRPF_WORD_W-1:0] word_s2_q;
	reg clk_s2_q;
	reg clk_s3_q;
	reg [`LRPF_WORD_W-1:0] ring_q [0:RING_DEPTH-1];
	reg [AW-1:0] wr_q;
	reg [AW-1:0] rd_q;
	reg [1:0] state_q;
	reg [1:0] state_d;
	reg [1:0] lane_q;
	reg [`LRPF_LINE_W-1:0] acc_q;
	reg [`LRPF_LINE_BYTES-1:0] acc_ctl_q;
	reg push_q;
	wire link_edge;
	wire [AW-1:0] sep;
	wire rd_ok;
	wire fifo_ready;
	wire do_read;
	wire read_slot;
	integer i;

	// Distance from the write pointer back to the read pointer, modulo the ring.
	function [AW-1:0] ptr_dist;
		input [AW-1:0] a;
		input [AW-1:0] b;
		begin
			ptr_dist = a - b;
		end
	endfunction

	// ----------------------------------------
	// Pin sampling
	// ----------------------------------------
	// Two flops before any logic looks at the forwarded clock or the lanes.
	// The third clock flop only feeds the edge detector; no logic reads a first-stage flop.
	always @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			clk_s1_q <= 1'b0;
			clk_s2_q <= 1'b0;
			clk_s3_q <= 1'b0;
			word_s1_q <= {`LRPF_WORD_W{1'b0}};
			word_s2_q <= {`LRPF_WORD_W{1'b0}};
		end
		else
		begin
			clk_s1_q <= forwarded_clock_input_i;
			clk_s2_q <= clk_s1_q;
			clk_s3_q <= clk_s2_q;
			word_s1_q <= {link_control_input_i, link_data_input_i};
			word_s2_q <= word_s1_q;
		end
	end

	// Rising edge of the sampled forwarded clock is the write strobe. Data lag matches clock lag.
	assign link_edge = clk_s2_q & ~clk_s3_q;

	// ----------------------------------------
	// Write side
	// ----------------------------------------
	// The write pointer restarts at link init; every forwarded edge writes one word.
	// The ring is cleared at the same time. The first reads after start land on slots
	// that hold nothing from this session; they must read as idle fill, not as stale
	// bytes of an earlier session or as unknown values.
	always @(posedge sys_clk_i)
	begin
		if (srst_i || link_init_i)
		begin
			wr_q <= {AW{1'b0}};
			for (i = 0; i < RING_DEPTH; i = i + 1)
				ring_q[i] <= {`LRPF_WORD_W{1'b0}};
		end
		else if (link_edge)
		begin
			ring_q[wr_q] <= word_s2_q;
			wr_q <= wr_q + 1'b1;
		end
	end

	// ----------------------------------------
	// Read pointer control
	// ----------------------------------------
	assign sep = ptr_dist(wr_q, rd_q);
	// In pseudo mode reading needs the minimum stable distance and a short gap stalls the read; sync mode skips the check.
	assign rd_ok = (clk_mode_i == `LRPF_MODE_SYNC) ? 1'b1 : (sep >= `LRPF_MIN_SEP);
	// Synchronous mode reads once per forwarded edge, so the start distance holds unless the output FIFO stalls a read.
	// Pseudo mode lets the core read on any cycle; the distance check then holds the
	// pointer back between link words, which is the periodic stall.
	assign read_slot = (clk_mode_i == `LRPF_MODE_SYNC) ? link_edge : 1'b1;
	assign do_read = (state_q == ST_RUN) && read_slot && rd_ok && fifo_ready;

	// Start waits until lanes read low in the core domain.
	always @*
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: if (link_init_i) state_d = ST_WAIT_LOW;
			ST_WAIT_LOW: if (word_s2_q == {`LRPF_WORD_W{1'b0}} && link_edge) state_d = ST_RUN;
			ST_RUN: if (link_init_i) state_d = ST_WAIT_LOW;
			default: state_d = ST_IDLE;
		endcase
	end

	// The read pointer sits INIT_OFFSET behind the write pointer, meeting both distances at once.
	always @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			state_q <= ST_IDLE;
			rd_q <= {AW{1'b0}};
		end
		else
		begin
			state_q <= state_d;
			if (state_q == ST_WAIT_LOW && state_d == ST_RUN)
				rd_q <= wr_q - INIT_OFFSET + 1'b1;
			else if (do_read)
				rd_q <= rd_q + 1'b1;
		end
	end

	// Flag a write edge that finds the distance above LRPF_MAX_SEP; the read side was too slow.
	// The distance wraps at the ring depth, so a stall that laps the ring looks short
	// again; the flag is sticky so that the first crossing is kept.
	always @(posedge sys_clk_i)
	begin
		if (srst_i || link_init_i)
			overrun_o <= 1'b0;
		else if (state_q == ST_RUN && link_edge && sep > `LRPF_MAX_SEP)
			overrun_o <= 1'b1;
	end

	// ----------------------------------------
	// Width conversion
	// ----------------------------------------
	// Bytes gather into a line; the line is pushed only when all lanes are written.
	// Lines do not realign to packet framing: lane 0 is simply the first read after start.
	// The accumulator is not touched while a push waits, since reads need a ready buffer.
	always @(posedge sys_clk_i)
	begin
		if (srst_i || link_init_i)
		begin
			lane_q <= 2'h0;
			push_q <= 1'b0;
			acc_q <= {`LRPF_LINE_W{1'b0}};
			acc_ctl_q <= {`LRPF_LINE_BYTES{1'b0}};
		end
		else
		begin
			if (push_q && fifo_ready)
				push_q <= 1'b0;
			if (do_read)
			begin
				acc_q[lane_q*8 +: 8] <= ring_q[rd_q][`LRPF_LINK_W-1:0];
				acc_ctl_q[lane_q] <= ring_q[rd_q][`LRPF_LINK_W];
				lane_q <= lane_q + 1'b1;
				if (lane_q == 2'h3)
					push_q <= 1'b1;
			end
		end
	end

	// Output FIFO; its ready stalls the read pointer, so back-pressure reaches the ring.
	lrpf_fifo #(
		.WIDTH(`LRPF_LINE_W + `LRPF_LINE_BYTES),
		.DEPTH(`LRPF_OUT_DEPTH),
		.AW(`LRPF_OUT_AW)
	) u_out (
		.sys_clk_i(sys_clk_i),
		.srst_i(srst_i),
		.in_valid_i(push_q),
		.in_ready_o(fifo_ready),
		.in_data_i({acc_ctl_q, acc_q}),
		.out_valid_o(line_valid_o),
		.out_ready_i(line_ready_i),
		.out_data_o({line_ctl_o, line_data_o})
	);

	assign running_o = (state_q == ST_RUN);
endmodule
`default_nettype wire

// ==== bench/lrpf_rx_monitor.sv ====
// Purpose: Port assertions for the receive phase FIFO.
// Assumes: Bound to lrpf_rx, one core clock domain.
// Notes: Hold checks tie the outputs to the consumer handshake.
`timescale 1ns/10ps
`default_nettype none
module lrpf_rx_monitor (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic link_init_i,
	input wire logic line_ready_i,
	input wire logic line_valid_o,
	input wire logic [31:0] line_data_o,
	input wire logic [3:0] line_ctl_o,
	input wire logic running_o,
	input wire logic overrun_o
);
	// ----------------------------------------
	// Port relations
	// ----------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);
	reset_quiet_a: assert property ($fell(srst_i) |-> !line_valid_o && !running_o && !overrun_o)
		else $error("Outputs active after reset.");
	init_rearm_a: assert property (link_init_i |=> !running_o && !overrun_o)
		else $error("Link init did not rearm.");
	valid_hold_a: assert property (line_valid_o && !line_ready_i && !link_init_i |=> line_valid_o)
		else $error("Line dropped without pop.");
	line_stable_a: assert property (line_valid_o && !line_ready_i |=> $stable({line_ctl_o, line_data_o}))
		else $error("Line changed while waiting.");
	pop_only_a: assert property ($fell(line_valid_o) |-> $past(line_ready_i) || $past(link_init_i))
		else $error("Valid fell without pop.");
	overrun_keep_a: assert property (overrun_o && !link_init_i |=> overrun_o)
		else $error("Overrun flag not sticky.");
	run_keep_a: assert property (running_o && !link_init_i |=> running_o)
		else $error("Read side stopped.");
	valid_run_a: assert property ($rose(line_valid_o) |-> running_o)
		else $error("Line before read start.");
	run_start_c: cover property ($rose(running_o));
	line_pop_c: cover property (line_valid_o && line_ready_i);
	overrun_c: cover property ($rose(overrun_o));
endmodule
`default_nettype wire

// ==== bench/lrpf_tx_model.sv ====
// Purpose: Far-side transmitter driving the forwarded clock and lanes.
// Assumes: One word per 200 ns bit time, clock low between frames.
// Notes: Lanes turn to the inverse after each falling edge, past hold.
`timescale 1ns/10ps
`default_nettype none
module lrpf_tx_model (
	output logic fwd_clk_o,
	output logic [7:0] data_o,
	output logic ctl_o
);
	initial
	begin
		fwd_clk_o = 1'b0;
		data_o = 8'h00;
		ctl_o = 1'b0;
	end
	// Each half of the clock spans four core cycles, above the three needed.
	task send(input logic [7:0] d, input logic c);
		data_o = d;
		ctl_o = c;
		#50 fwd_clk_o = 1'b1;
		#100 fwd_clk_o = 1'b0;
		data_o = ~d;
		ctl_o = ~c;
		#50;
	endtask
endmodule
`default_nettype wire

// ==== bench/test_lrpf_rx.sv ====
// Purpose: Self-checking bench for the receive phase FIFO.
// Assumes: Default ring depth and read offset.
// Notes: Zero lines are idle fill and are not collected.
`timescale 1ns/10ps
`default_nettype none
module test_lrpf_rx;
	logic sys_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic link_init_i = 1'b0;
	logic clk_mode_i = 1'b0;
	logic line_ready_i = 1'b1;
	wire logic fwd_clk;
	wire logic [7:0] lane_d;
	wire logic lane_c;
	wire logic line_valid_o;
	wire logic [31:0] line_data_o;
	wire logic [3:0] line_ctl_o;
	wire logic running_o;
	wire logic overrun_o;
	int error_cnt = 0;
	int n_tests = 0;
	int n;
	logic [35:0] got_q[$];
	lrpf_rx i_lrpf_rx (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .link_init_i(link_init_i),
		.clk_mode_i(clk_mode_i), .forwarded_clock_input_i(fwd_clk), .link_data_input_i(lane_d),
		.link_control_input_i(lane_c), .line_valid_o(line_valid_o), .line_ready_i(line_ready_i),
		.line_data_o(line_data_o), .line_ctl_o(line_ctl_o), .running_o(running_o), .overrun_o(overrun_o));
	lrpf_tx_model i_lrpf_tx_model (.fwd_clk_o(fwd_clk), .data_o(lane_d), .ctl_o(lane_c));
	always #12.5 sys_clk_i = ~sys_clk_i;
	// Popped lines are kept so a task can judge them after the frame.
	always @(posedge sys_clk_i)
		if (line_valid_o === 1'b1 && line_ready_i === 1'b1 && line_data_o !== 32'h0000_0000)
			got_q.push_back({line_ctl_o, line_data_o});
	task chk(input logic [35:0] s, input logic [35:0] e);
		n_tests++;
		if (s !== e)
		begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task end_sim;
		$display("Checks %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Init pulse, then low words; the offset phase keeps link edges off core edges.
	// Five low words put the first data byte in lane 0, after three idle lines.
	task start_link(input logic m);
		@(posedge sys_clk_i);
		clk_mode_i <= m;
		link_init_i <= 1'b1;
		@(posedge sys_clk_i);
		link_init_i <= 1'b0;
		#7;
		repeat (5) i_lrpf_tx_model.send(8'h00, 1'b0);
		chk({35'h0, running_o}, 36'h1);
	endtask
	task s_line(input logic m);
		got_q.delete();
		start_link(m);
		for (n = 1; n <= 8; n++)
			i_lrpf_tx_model.send(8'(n * 17), n[0]);
		repeat (12) i_lrpf_tx_model.send(8'h00, 1'b0);
		repeat (8) @(posedge sys_clk_i);
		chk(36'(got_q.size()), 36'h2);
		chk(got_q[0], 36'h5_4433_2211);
		chk(got_q[1], 36'h5_8877_6655);
	endtask
	// Stalled consumer: output buffer fills, ring passes its limit.
	task s_overrun;
		@(posedge sys_clk_i);
		line_ready_i <= 1'b0;
		start_link(1'b0);
		repeat (60) i_lrpf_tx_model.send(8'hA5, 1'b1);
		chk({34'h0, line_valid_o, overrun_o}, 36'h3);
		@(posedge sys_clk_i);
		link_init_i <= 1'b1;
		line_ready_i <= 1'b1;
		@(posedge sys_clk_i);
		link_init_i <= 1'b0;
		@(negedge sys_clk_i);
		chk({35'h0, overrun_o}, 36'h0);
		for (n = 0; n < 40 && line_valid_o !== 1'b0; n++)
			@(posedge sys_clk_i);
		chk({35'h0, line_valid_o}, 36'h0);
	endtask
	initial
	begin
		#400000;
		error_cnt++;
		end_sim();
	end
	initial
	begin
		repeat (8) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		s_line(1'b0);
		s_line(1'b1);
		s_overrun();
		end_sim();
	end
endmodule
bind lrpf_rx lrpf_rx_monitor i_lrpf_rx_monitor (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
	.link_init_i(link_init_i), .line_ready_i(line_ready_i), .line_valid_o(line_valid_o),
	.line_data_o(line_data_o), .line_ctl_o(line_ctl_o), .running_o(running_o), .overrun_o(overrun_o));
`default_nettype wire
